//--- bench/imu_pipe_model.sv
// Pipeline-side partner: general register file fed by the write-back port.
// Assumes the same core clock and reset as the unit.
`timescale 1ns/1ps
`default_nettype none
module imu_pipe_model (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        wb_valid,
   input wire logic [4:0]  wb_index,
   input wire logic [31:0] wb_data
);
   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [31:0] gpr_r [32];
   // Index zero stays zero, so a stray write there is dropped and never shows up
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 32; i++) gpr_r[i] <= 32'h0;
      end
      else if (wb_valid && wb_index != 5'h0)
      begin
         gpr_r[wb_index] <= wb_data;
      end
   end
endmodule
`default_nettype wire

//--- bench/imu_top_chk.sv
// Port checker for the multiply unit, attached by bind.
// Assumes one core clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module imu_top_chk (
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              issue_valid,
   input wire imu_pkg::imu_op_t  issue_op,
   input wire logic [31:0]       src_a_data,
   input wire logic              issue_ready,
   input wire logic              read_upper_req,
   input wire logic              read_bottom_req,
   input wire logic              pair_stall,
   input wire logic [31:0]       upper_value,
   input wire logic [31:0]       bottom_value,
   input wire logic              gpr_stall,
   input wire logic              wb_valid,
   input wire logic [4:0]        wb_index,
   input wire logic              busy
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic take;
   assign take = issue_valid && issue_ready;
   property p_wr_bottom;
      take && issue_op == imu_pkg::IMU_OP_WRITE_BOTTOM |=> bottom_value == $past(src_a_data);
   endproperty
   a_wr_bottom: assert property (p_wr_bottom) else $error("bottom write lost");
   property p_wr_upper;
      take && issue_op == imu_pkg::IMU_OP_WRITE_UPPER |=> upper_value == $past(src_a_data);
   endproperty
   a_wr_upper: assert property (p_wr_upper) else $error("upper write lost");
   property p_ready_idle;
      !busy |-> issue_ready;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("idle unit refused work");
   property p_stall_cause;
      pair_stall |-> busy && (read_upper_req || read_bottom_req);
   endproperty
   a_stall_cause: assert property (p_stall_cause) else $error("pair stall without cause");
   // Latency is at most 32 steps plus the landing cycle
   property p_busy_bound;
      $rose(busy) |-> ##[1:33] !busy;
   endproperty
   a_busy_bound: assert property (p_busy_bound) else $error("multiply never ends");
   property p_mul_start;
      take && issue_op inside {imu_pkg::IMU_OP_PRODUCT_TO_REG, imu_pkg::IMU_OP_SIGNED_PRODUCT,
                               imu_pkg::IMU_OP_UNSIGNED_PRODUCT} |=> busy;
   endproperty
   a_mul_start: assert property (p_mul_start) else $error("multiply not started");
   property p_upper_src;
      !$stable(upper_value) |-> $past(busy) || $past(take && issue_op == imu_pkg::IMU_OP_WRITE_UPPER);
   endproperty
   a_upper_src: assert property (p_upper_src) else $error("upper changed on its own");
   property p_wb_pulse;
      wb_valid |-> $past(busy) && wb_index != 5'h0 ##1 !wb_valid;
   endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("bad write-back pulse");
   property p_gpr_stall;
      gpr_stall |-> busy || wb_valid;
   endproperty
   a_gpr_stall: assert property (p_gpr_stall) else $error("interlock without cause");
endmodule
bind imu_top imu_top_chk chk_u (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid),
   .issue_op(issue_op), .src_a_data(src_a_data), .issue_ready(issue_ready),
   .read_upper_req(read_upper_req), .read_bottom_req(read_bottom_req), .pair_stall(pair_stall),
   .upper_value(upper_value), .bottom_value(bottom_value), .gpr_stall(gpr_stall),
   .wb_valid(wb_valid), .wb_index(wb_index), .busy(busy));
`default_nettype wire

//--- bench/test_integer_multiply_unit.sv
// Self-checking bench for the multiply unit.
// Assumes the unit top and the pipeline partner model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_integer_multiply_unit;
   logic clock, rst_n, issue_valid, read_upper_req, read_bottom_req, check_a_valid, check_b_valid;
   logic issue_ready, pair_stall, gpr_stall, wb_valid, busy, result_unread, upper_stale, bottom_stale;
   imu_pkg::imu_op_t issue_op;
   logic [31:0] src_a_data, src_b_data, upper_value, bottom_value, wb_data;
   logic [4:0] dest_index, check_a_index, check_b_index, wb_index;
   int n_fail, total_checks;
   imu_top dut_u (.clock(clock), .rst_n(rst_n), .issue_valid(issue_valid), .issue_op(issue_op),
      .src_a_data(src_a_data), .src_b_data(src_b_data), .dest_index(dest_index),
      .issue_ready(issue_ready), .read_upper_req(read_upper_req), .read_bottom_req(read_bottom_req),
      .pair_stall(pair_stall), .upper_value(upper_value), .bottom_value(bottom_value),
      .check_a_valid(check_a_valid), .check_a_index(check_a_index), .check_b_valid(check_b_valid),
      .check_b_index(check_b_index), .gpr_stall(gpr_stall), .wb_valid(wb_valid),
      .wb_index(wb_index), .wb_data(wb_data), .busy(busy), .result_unread(result_unread),
      .upper_stale(upper_stale), .bottom_stale(bottom_stale));
   imu_pipe_model pipe_u (.clock(clock), .rst_n(rst_n), .wb_valid(wb_valid), .wb_index(wb_index),
      .wb_data(wb_data));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Called at a falling edge; returns at the falling edge after the take with valid still high
   task automatic issue(input imu_pkg::imu_op_t op, input logic [31:0] a, b, input logic [4:0] d);
      int n;
      issue_valid = 1'b1;
      issue_op = op;
      src_a_data = a;
      src_b_data = b;
      dest_index = d;
      n = 0;
      while (issue_ready !== 1'b1 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
      chk(issue_ready, 64'h1);
      @(negedge clock);
   endtask
   task automatic idle_wait();
      int n;
      issue_valid = 1'b0;
      issue_op = imu_pkg::IMU_OP_NONE;
      n = 0;
      while (busy !== 1'b0 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
      chk(busy, 64'h0);
   endtask
   task automatic read_pair();
      read_bottom_req = 1'b1;
      @(negedge clock);
      read_bottom_req = 1'b0;
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_writes();
      issue(imu_pkg::IMU_OP_WRITE_BOTTOM, 32'h1234_5678, 32'h0, 5'h0);
      issue(imu_pkg::IMU_OP_WRITE_UPPER, 32'h9abc_def0, 32'h0, 5'h0);
      chk(bottom_value, 64'h1234_5678);
      read_upper_req = 1'b1;
      chk(upper_value, 64'h9abc_def0);
      issue(imu_pkg::IMU_OP_WRITE_UPPER, 32'h0f0f_0f0f, 32'h0, 5'h0);
      read_upper_req = 1'b0;
      idle_wait();
      chk(upper_value, 64'h0f0f_0f0f);
   endtask
   task automatic t_products();
      logic [31:0] ta [4] = '{32'hffff_ffff, 32'h8000_0000, 32'h7fff_ffff, 32'h0000_0003};
      logic [31:0] tb [4] = '{32'hffff_ffff, 32'h8000_0000, 32'h0000_0002, 32'h0000_0000};
      logic [63:0] exp;
      for (int i = 0; i < 4; i++)
      begin
         for (int s = 0; s < 2; s++)
         begin
            issue(s ? imu_pkg::IMU_OP_SIGNED_PRODUCT : imu_pkg::IMU_OP_UNSIGNED_PRODUCT, ta[i], tb[i], 5'h0);
            idle_wait();
            exp = s ? 64'($signed({{32{ta[i][31]}}, ta[i]}) * $signed({{32{tb[i][31]}}, tb[i]}))
                    : {32'h0, ta[i]} * {32'h0, tb[i]};
            chk({upper_value, bottom_value}, exp);
            read_pair();
         end
      end
   endtask
   task automatic t_pair_stall();
      int n;
      issue(imu_pkg::IMU_OP_SIGNED_PRODUCT, 32'h0000_0005, 32'h7fff_ffff, 5'h0);
      issue_valid = 1'b0;
      read_upper_req = 1'b1;
      @(negedge clock);
      chk(pair_stall, 64'h1);
      n = 0;
      while (pair_stall !== 1'b0 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
      chk({upper_value, bottom_value}, 64'h0000_0002_7fff_fffb);
      // Keep the read up one more edge so it is taken once the stall drops
      @(negedge clock);
      chk(result_unread, 64'h0);
      read_upper_req = 1'b0;
      idle_wait();
   endtask
   task automatic t_gpr_interlock();
      int n;
      issue(imu_pkg::IMU_OP_PRODUCT_TO_REG, 32'hffff_fffd, 32'h4000_0001, 5'h05);
      issue_valid = 1'b0;
      check_a_valid = 1'b1;
      check_a_index = 5'h05;
      check_b_valid = 1'b1;
      check_b_index = 5'h00;
      @(negedge clock);
      chk(gpr_stall, 64'h1);
      n = 0;
      while (gpr_stall !== 1'b0 && n < 100)
      begin
         @(negedge clock);
         n++;
      end
      chk(pipe_u.gpr_r[5], 64'h3fff_fffd);
      check_a_valid = 1'b0;
      check_b_valid = 1'b0;
      idle_wait();
   endtask
   // Deliberately writes over an unread result to see the bottom half still lands
   task automatic t_bottom_over_unread();
      issue(imu_pkg::IMU_OP_UNSIGNED_PRODUCT, 32'h0001_0000, 32'h0000_0010, 5'h0);
      idle_wait();
      chk({upper_value, bottom_value}, 64'h0000_0000_0010_0000);
      chk(result_unread, 64'h1);
      issue(imu_pkg::IMU_OP_WRITE_BOTTOM, 32'h5555_aaaa, 32'h0, 5'h0);
      idle_wait();
      chk(bottom_value, 64'h5555_aaaa);
      chk(result_unread, 64'h0);
      chk(upper_stale, 64'h1);
      issue(imu_pkg::IMU_OP_SIGNED_PRODUCT, 32'h0000_0002, 32'h0000_0003, 5'h0);
      idle_wait();
      issue(imu_pkg::IMU_OP_WRITE_UPPER, 32'h3333_cccc, 32'h0, 5'h0);
      idle_wait();
      chk(upper_value, 64'h3333_cccc);
      chk(upper_stale, 64'h0);
      chk(bottom_stale, 64'h1);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial
   begin
      repeat (5000) @(posedge clock);
      n_fail++;
      summarize();
   end
   initial
   begin
      n_fail = 0;
      total_checks = 0;
      rst_n = 1'b0;
      {issue_valid, read_upper_req, read_bottom_req, check_a_valid, check_b_valid} = 5'h0;
      issue_op = imu_pkg::IMU_OP_NONE;
      {src_a_data, src_b_data} = 64'h0;
      {dest_index, check_a_index, check_b_index} = 15'h0;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      chk(issue_ready, 64'h1);
      chk(upper_value, 64'(imu_pkg::UPPER_RST));
      t_writes();
      t_products();
      t_pair_stall();
      t_gpr_interlock();
      t_bottom_over_unread();
      summarize();
   end
endmodule
`default_nettype wire

//--- common/imu_pkg.sv
// Shared constants and types of the integer multiply unit.
// Assumes a single core clock and a synchronous active-low reset everywhere.

package imu_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int WORD_W = 32;
   localparam int PROD_W = 64;
   localparam int IDX_W  = 5;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [WORD_W-1:0] UPPER_RST  = 32'h0000_0000;
   localparam logic [WORD_W-1:0] BOTTOM_RST = 32'h0000_0000;
   localparam logic [WORD_W-1:0] WB_RST     = 32'h0000_0000;
   localparam logic [IDX_W-1:0]  IDX_RST    = 5'h00;
   localparam logic [PROD_W-1:0] PROD_RST   = 64'h0000_0000_0000_0000;

   // Register index that is hardwired to zero in the register file
   localparam logic [IDX_W-1:0]  ZERO_IDX   = 5'h00;

   // ----------------------------------------
   // Operations offered by the pipeline
   // ----------------------------------------
   typedef enum logic [2:0] {
      IMU_OP_NONE             = 3'b000,
      IMU_OP_WRITE_BOTTOM     = 3'b001,
      IMU_OP_WRITE_UPPER      = 3'b010,
      IMU_OP_PRODUCT_TO_REG   = 3'b011,
      IMU_OP_SIGNED_PRODUCT   = 3'b100,
      IMU_OP_UNSIGNED_PRODUCT = 3'b101
   } imu_op_t;

   // Where a running multiply delivers its result
   typedef enum logic {
      IMU_DST_PAIR = 1'b0,
      IMU_DST_GPR  = 1'b1
   } imu_dst_t;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      IMU_ST_IDLE = 2'b00,
      IMU_ST_RUN  = 2'b01
   } imu_state_t;

endpackage

//--- rtl/imu_mul_core.sv
// Iterative shift-add 32x32 multiplier, signed or unsigned.
// Assumes start is only raised while no multiply is running.

`timescale 1ns/1ps
`default_nettype none

module imu_mul_core (
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        start,
   input  wire logic                        signed_mode,
   input  wire logic [imu_pkg::WORD_W-1:0] mcand_in,
   input  wire logic [imu_pkg::WORD_W-1:0] mplier_in,
   output logic                             done,
   output logic      [imu_pkg::PROD_W-1:0] product
);

   // ----------------------------------------
   // Magnitude of an operand
   // ----------------------------------------
   function automatic logic [imu_pkg::WORD_W-1:0] imu_mag(
      input logic [imu_pkg::WORD_W-1:0] v,
      input logic                       sgn
   );
      imu_mag = (sgn && v[imu_pkg::WORD_W-1]) ? (~v + 32'h0000_0001) : v;
   endfunction

   logic                        run_r,    run_nxt;
   logic                        neg_r,    neg_nxt;
   logic                        done_r,   done_nxt;
   logic [imu_pkg::PROD_W-1:0] acc_r,    acc_nxt;
   logic [imu_pkg::PROD_W-1:0] mcand_r,  mcand_nxt;
   logic [imu_pkg::WORD_W-1:0] mplier_r, mplier_nxt;
   logic [imu_pkg::PROD_W-1:0] prod_r,   prod_nxt;
   logic [imu_pkg::PROD_W-1:0] sum;

   // ----------------------------------------
   // Step logic
   // ----------------------------------------
   // Stops as soon as the multiplier runs out of ones, so a short second operand is fast
   always_comb
   begin
      run_nxt    = run_r;
      neg_nxt    = neg_r;
      acc_nxt    = acc_r;
      mcand_nxt  = mcand_r;
      mplier_nxt = mplier_r;
      prod_nxt   = prod_r;
      done_nxt   = 1'b0;
      sum        = acc_r;
      if (start)
      begin
         mcand_nxt  = {32'h0000_0000, imu_mag(mcand_in, signed_mode)};
         mplier_nxt = imu_mag(mplier_in, signed_mode);
         neg_nxt    = signed_mode & (mcand_in[31] ^ mplier_in[31]);
         acc_nxt    = imu_pkg::PROD_RST;
         run_nxt    = 1'b1;
      end
      else if (run_r)
      begin
         sum        = mplier_r[0] ? (acc_r + mcand_r) : acc_r;
         acc_nxt    = sum;
         mcand_nxt  = {mcand_r[62:0], 1'b0};
         mplier_nxt = {1'b0, mplier_r[31:1]};
         if (mplier_nxt == 32'h0000_0000)
         begin
            run_nxt  = 1'b0;
            done_nxt = 1'b1;
            // Full 64-bit result, no overflow flag exists
            prod_nxt = neg_r ? (~sum + 64'h0000_0000_0000_0001) : sum;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         run_r    <= 1'b0;
         neg_r    <= 1'b0;
         done_r   <= 1'b0;
         acc_r    <= imu_pkg::PROD_RST;
         mcand_r  <= imu_pkg::PROD_RST;
         mplier_r <= imu_pkg::WB_RST;
         prod_r   <= imu_pkg::PROD_RST;
      end
      else
      begin
         run_r    <= run_nxt;
         neg_r    <= neg_nxt;
         done_r   <= done_nxt;
         acc_r    <= acc_nxt;
         mcand_r  <= mcand_nxt;
         mplier_r <= mplier_nxt;
         prod_r   <= prod_nxt;
      end
   end

   assign done    = done_r;
   assign product = prod_r;

endmodule

`default_nettype wire

//--- rtl/imu_top.sv
// Integer multiply unit: upper/bottom product pair, multiplies and interlocks.
// Assumes the pipeline hands over source register values with each operation
// and owns the general register file that the write-back port feeds.

`timescale 1ns/1ps
`default_nettype none

module imu_top (
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   input  wire logic                         issue_valid,
   input  wire imu_pkg::imu_op_t             issue_op,
   input  wire logic  [imu_pkg::WORD_W-1:0] src_a_data,
   input  wire logic  [imu_pkg::WORD_W-1:0] src_b_data,
   input  wire logic  [imu_pkg::IDX_W-1:0]  dest_index,
   output logic                              issue_ready,
   input  wire logic                         read_upper_req,
   input  wire logic                         read_bottom_req,
   output logic                              pair_stall,
   output logic       [imu_pkg::WORD_W-1:0] upper_value,
   output logic       [imu_pkg::WORD_W-1:0] bottom_value,
   input  wire logic                         check_a_valid,
   input  wire logic  [imu_pkg::IDX_W-1:0]  check_a_index,
   input  wire logic                         check_b_valid,
   input  wire logic  [imu_pkg::IDX_W-1:0]  check_b_index,
   output logic                              gpr_stall,
   output logic                              wb_valid,
   output logic       [imu_pkg::IDX_W-1:0]  wb_index,
   output logic       [imu_pkg::WORD_W-1:0] wb_data,
   output logic                              busy,
   output logic                              result_unread,
   output logic                              upper_stale,
   output logic                              bottom_stale
);

   // ----------------------------------------
   // Operation decoding
   // ----------------------------------------
   function automatic logic imu_is_mul(input imu_pkg::imu_op_t op);
      imu_is_mul = (op == imu_pkg::IMU_OP_PRODUCT_TO_REG) ||
                   (op == imu_pkg::IMU_OP_SIGNED_PRODUCT) ||
                   (op == imu_pkg::IMU_OP_UNSIGNED_PRODUCT);
   endfunction

   function automatic logic imu_hit(
      input logic                      vld,
      input logic [imu_pkg::IDX_W-1:0] idx,
      input logic [imu_pkg::IDX_W-1:0] dst
   );
      imu_hit = vld && (idx == dst) && (dst != imu_pkg::ZERO_IDX);
   endfunction

   imu_pkg::imu_state_t         state_r,   state_nxt;
   imu_pkg::imu_dst_t           dst_r,     dst_nxt;
   logic [imu_pkg::IDX_W-1:0]  dest_r,    dest_nxt;
   logic [imu_pkg::WORD_W-1:0] upper_r,   upper_nxt;
   logic [imu_pkg::WORD_W-1:0] bottom_r,  bottom_nxt;
   logic                        unread_r,  unread_nxt;
   logic                        ustale_r,  ustale_nxt;
   logic                        bstale_r,  bstale_nxt;
   logic                        wbv_r,     wbv_nxt;
   logic [imu_pkg::IDX_W-1:0]  wbi_r,     wbi_nxt;
   logic [imu_pkg::WORD_W-1:0] wbd_r,     wbd_nxt;

   logic                        take;
   logic                        start;
   logic                        signed_mode;
   logic                        read_taken;
   logic                        core_done;
   logic [imu_pkg::PROD_W-1:0] core_product;

   // ----------------------------------------
   // Issue handshake
   // ----------------------------------------
   // One multiply at a time; every unit operation waits while one is running,
   // which keeps program order for writes to the pair
   assign issue_ready = (state_r == imu_pkg::IMU_ST_IDLE);
   assign take        = issue_valid && issue_ready;
   assign start       = take && imu_is_mul(issue_op);
   assign signed_mode = (issue_op != imu_pkg::IMU_OP_UNSIGNED_PRODUCT);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      dst_nxt   = dst_r;
      dest_nxt  = dest_r;
      case (state_r)
         imu_pkg::IMU_ST_IDLE:
         begin
            if (start)
            begin
               state_nxt = imu_pkg::IMU_ST_RUN;
               dest_nxt  = dest_index;
               dst_nxt   = (issue_op == imu_pkg::IMU_OP_PRODUCT_TO_REG) ?
                           imu_pkg::IMU_DST_GPR : imu_pkg::IMU_DST_PAIR;
            end
         end
         imu_pkg::IMU_ST_RUN:
         begin
            if (core_done)
            begin
               state_nxt = imu_pkg::IMU_ST_IDLE;
            end
         end
         default:
         begin
            state_nxt = imu_pkg::IMU_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_r <= imu_pkg::IMU_ST_IDLE;
         dst_r   <= imu_pkg::IMU_DST_PAIR;
         dest_r  <= imu_pkg::IDX_RST;
      end
      else
      begin
         state_r <= state_nxt;
         dst_r   <= dst_nxt;
         dest_r  <= dest_nxt;
      end
   end

   // ----------------------------------------
   // Multiplier
   // ----------------------------------------
   // Source B is the operand whose length sets the latency
   imu_mul_core u_core (
      .clock       (clock),
      .rst_n       (rst_n),
      .start       (start),
      .signed_mode (signed_mode),
      .mcand_in    (src_a_data),
      .mplier_in   (src_b_data),
      .done        (core_done),
      .product     (core_product)
   );

   // ----------------------------------------
   // Upper and bottom product pair
   // ----------------------------------------
   // Reads are taken straight from the registers, so a write in the same
   // cycle lands only at the edge and the read still sees the old value
   assign read_taken = (read_upper_req || read_bottom_req) && !pair_stall;

   always_comb
   begin
      upper_nxt  = upper_r;
      bottom_nxt = bottom_r;
      unread_nxt = unread_r;
      ustale_nxt = ustale_r;
      bstale_nxt = bstale_r;
      if (read_taken)
      begin
         unread_nxt = 1'b0;
      end
      if (take && (issue_op == imu_pkg::IMU_OP_WRITE_BOTTOM))
      begin
         bottom_nxt = src_a_data;
         bstale_nxt = 1'b0;
         // Upper half keeps the old product, flagged as not to be trusted if the pair was still unread
         ustale_nxt = unread_r && !read_taken;
         unread_nxt = 1'b0;
      end
      if (take && (issue_op == imu_pkg::IMU_OP_WRITE_UPPER))
      begin
         upper_nxt  = src_a_data;
         ustale_nxt = 1'b0;
         bstale_nxt = unread_r && !read_taken;
         unread_nxt = 1'b0;
      end
      // Product-to-register leaves the pair untouched
      if (core_done && (dst_r == imu_pkg::IMU_DST_PAIR))
      begin
         bottom_nxt = core_product[31:0];
         upper_nxt  = core_product[63:32];
         ustale_nxt = 1'b0;
         bstale_nxt = 1'b0;
         // Completion sets the flag last so it wins over a clear
         unread_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         upper_r  <= imu_pkg::UPPER_RST;
         bottom_r <= imu_pkg::BOTTOM_RST;
         unread_r <= 1'b0;
         ustale_r <= 1'b0;
         bstale_r <= 1'b0;
      end
      else
      begin
         upper_r  <= upper_nxt;
         bottom_r <= bottom_nxt;
         unread_r <= unread_nxt;
         ustale_r <= ustale_nxt;
         bstale_r <= bstale_nxt;
      end
   end

   // ----------------------------------------
   // General register write-back
   // ----------------------------------------
   // Register zero is hardwired, so no write-back is raised for it
   always_comb
   begin
      wbv_nxt = 1'b0;
      wbi_nxt = wbi_r;
      wbd_nxt = wbd_r;
      if (core_done && (dst_r == imu_pkg::IMU_DST_GPR))
      begin
         wbv_nxt = (dest_r != imu_pkg::ZERO_IDX);
         wbi_nxt = dest_r;
         wbd_nxt = core_product[31:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wbv_r <= 1'b0;
         wbi_r <= imu_pkg::IDX_RST;
         wbd_r <= imu_pkg::WB_RST;
      end
      else
      begin
         wbv_r <= wbv_nxt;
         wbi_r <= wbi_nxt;
         wbd_r <= wbd_nxt;
      end
   end

   // ----------------------------------------
   // Interlocks
   // ----------------------------------------
   // Pair reads wait for a running pair multiply; unrelated work goes on
   assign pair_stall = (state_r == imu_pkg::IMU_ST_RUN) &&
                       (dst_r == imu_pkg::IMU_DST_PAIR) &&
                       (read_upper_req || read_bottom_req);

   // The destination stays locked through the write-back cycle as well,
   // since the register file only holds the value after that edge
   assign gpr_stall =
      ((state_r == imu_pkg::IMU_ST_RUN) && (dst_r == imu_pkg::IMU_DST_GPR) &&
       (imu_hit(check_a_valid, check_a_index, dest_r) ||
        imu_hit(check_b_valid, check_b_index, dest_r))) ||
      (wbv_r && (imu_hit(check_a_valid, check_a_index, wbi_r) ||
                 imu_hit(check_b_valid, check_b_index, wbi_r)));

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign upper_value   = upper_r;
   assign bottom_value  = bottom_r;
   assign wb_valid      = wbv_r;
   assign wb_index      = wbi_r;
   assign wb_data       = wbd_r;
   assign busy          = (state_r == imu_pkg::IMU_ST_RUN);
   assign result_unread = unread_r;
   assign upper_stale   = ustale_r;
   assign bottom_stale  = bstale_r;

endmodule

`default_nettype wire
